// ==== hdl/eei_pkg.sv ====
// Shared constants and types of the external edge interrupt block
package eei_pkg;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [4:0] EEI_OFF_MODE_A = 5'h00;
	localparam logic [4:0] EEI_OFF_MODE_B = 5'h04;
	localparam logic [4:0] EEI_OFF_MODE_C = 5'h08;
	localparam logic [4:0] EEI_OFF_STAT   = 5'h0c;
	localparam logic [4:0] EEI_OFF_CLR    = 5'h10;
	localparam logic [4:0] EEI_OFF_EN     = 5'h14;
	localparam logic [4:0] EEI_OFF_PINS   = 5'h18;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int         EEI_NE_EN_BIT   = 2;
	localparam int         EEI_NE_CLK_BIT  = 3;
	localparam int         EEI_KEY_ALL_BIT = 0;
	localparam int         EEI_TEST_OFF_BIT = 1;
	localparam int         EEI_NFLAG       = 5;
	localparam logic [3:0] EEI_MODE_A_RST  = 4'h0;
	localparam logic       EEI_MODE_B_RST  = 1'b0;
	localparam logic [1:0] EEI_MODE_C_RST  = 2'h0;
	localparam logic [4:0] EEI_EN_RST      = 5'h00;
	localparam logic [3:0] EEI_KEY_UPPER   = 4'hc;
	localparam logic [3:0] EEI_KEY_ALL     = 4'hf;

	// Pin order: 0 both-edge, 1 input a, 2 input b, 3 test, 4..7 keys, 8 system reset
	localparam int         EEI_NPIN        = 9;
	localparam logic [8:0] EEI_PIN_RST     = 9'h1f0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int         EEI_CLK_NS      = 4;
	localparam int         EEI_MIN_W_NS    = 20;
	localparam int         EEI_MIN_W_CYC   = (EEI_MIN_W_NS + EEI_CLK_NS - 1) / EEI_CLK_NS;
	localparam logic [3:0] EEI_MIN_W_LAST  = 4'(EEI_MIN_W_CYC - 1);
	localparam int         EEI_NE_FAST_BITS = 6;
	localparam int         EEI_NE_SLOW_BITS = 8;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		EEI_RISE = 2'h0,
		EEI_FALL = 2'h1,
		EEI_BOTH = 2'h2,
		EEI_OFF  = 2'h3
	} eei_edge_e;

	typedef struct packed {
		logic      noise_clk;
		logic      noise_en;
		eei_edge_e edge_sel;
	} eei_mode_a_s;

	typedef struct packed {
		logic       sys_reset_b;
		logic [3:0] key_interrupt_lines;
		logic       rising_test_input;
		logic       selectable_edge_input_b;
		logic       selectable_edge_input_a;
		logic       both_edge_irq_input;
	} eei_pins_s;

endpackage

// ==== hdl/eei_top.sv ====
// External edge interrupt inputs with Avalon-MM register access
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns

module eei_top
	import eei_pkg::*;
(
	input  wire logic                mclk,            // 250 MHz clock
	input  wire logic                rst_b,           // Synchronous reset, low
	input  wire logic [4:0]          avs_address,     // Byte address
	input  wire logic                avs_read,        // Read request
	input  wire logic                avs_write,       // Write request
	input  wire logic [31:0]         avs_writedata,   // Write data
	output logic [31:0]              avs_readdata,    // Read data
	output logic                     avs_waitrequest, // Stall
	input  wire eei_pkg::eei_pins_s  pins,            // Asynchronous pins
	input  wire logic [2:0]          vec_ack,         // Vectored acknowledge pulses
	output logic                     irq,             // Level interrupt
	output logic                     test_input_flag, // Test flag
	output logic                     cpu_reset_req,   // CPU held in reset
	output logic                     standby_release  // Wake pulse
);
	import eei_pkg::*;

	// ----------------------------------------
	// Pin conditioning
	// ----------------------------------------
	logic [EEI_NPIN-1:0] pin_raw;
	logic [EEI_NPIN-1:0] pin_s3;
	logic [EEI_NPIN-1:0] lvl;
	logic [EEI_NPIN-1:0] lvl_d;
	logic [EEI_NPIN-1:0] rise;
	logic [EEI_NPIN-1:0] fall;

	assign pin_raw = pins;

	// A level is taken only after sync stages two and three agree, and then
	// only after it has held for the minimum width.
	for (genvar i = 0; i < EEI_NPIN; i++) begin : g_pin
		logic       s1;
		logic       s2;
		logic       s3;
		logic [3:0] cnt;
		logic       acc_lvl;

		always_ff @(posedge mclk) begin
			if (!rst_b) begin
				s1 <= EEI_PIN_RST[i];
				s2 <= EEI_PIN_RST[i];
				s3 <= EEI_PIN_RST[i];
			end else begin
				s1 <= pin_raw[i];
				s2 <= s1;
				s3 <= s2;
			end
		end

		always_ff @(posedge mclk) begin
			if (!rst_b) begin
				cnt     <= 4'h0;
				acc_lvl <= EEI_PIN_RST[i];
			end else if (s2 != s3 || s3 == acc_lvl) begin
				cnt <= 4'h0;
			end else if (cnt == EEI_MIN_W_LAST) begin
				cnt     <= 4'h0;
				acc_lvl <= s3;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end

		assign pin_s3[i] = s3;
		assign lvl[i]    = acc_lvl;
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			lvl_d <= EEI_PIN_RST;
		end else begin
			lvl_d <= lvl;
		end
	end

	assign rise = lvl & ~lvl_d;
	assign fall = ~lvl & lvl_d;

	// ----------------------------------------
	// System reset and bus handshake
	// ----------------------------------------
	logic srst;
	logic acc;
	logic wr;

	// A held system reset pin keeps the mode, enable, noise filter and flag registers and irq cleared
	assign srst = !rst_b || !lvl[8];
	assign acc  = (avs_read || avs_write) && !avs_waitrequest;
	assign wr   = acc && avs_write;

	// One wait cycle per access; the answer stands in the cycle after request
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	// ----------------------------------------
	// Mode registers
	// ----------------------------------------
	eei_mode_a_s mode_a;
	logic        mode_b;
	logic [1:0]  mode_c;
	logic [4:0]  en;

	always_ff @(posedge mclk) begin
		if (srst) begin
			mode_a <= EEI_MODE_A_RST;
			mode_b <= EEI_MODE_B_RST;
			mode_c <= EEI_MODE_C_RST;
		end else if (wr) begin
			if (avs_address == EEI_OFF_MODE_A) begin
				mode_a <= avs_writedata[3:0];
			end
			if (avs_address == EEI_OFF_MODE_B) begin
				mode_b <= avs_writedata[0];
			end
			if (avs_address == EEI_OFF_MODE_C) begin
				mode_c <= avs_writedata[1:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			en <= EEI_EN_RST;
		end else if (wr && avs_address == EEI_OFF_EN) begin
			en <= avs_writedata[4:0];
		end
	end

	// ----------------------------------------
	// Noise eliminator for input a
	// ----------------------------------------
	logic [7:0] ne_cnt;
	logic       ne_tick;
	logic       ne_smp;
	logic       ne_lvl;

	// The slow clock quadruples the rejected width at the price of latency
	assign ne_tick = mode_a.noise_clk ? (ne_cnt[EEI_NE_SLOW_BITS-1:0] == 8'h00)
	                                  : (ne_cnt[EEI_NE_FAST_BITS-1:0] == 6'h00);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ne_cnt <= 8'h00;
		end else begin
			ne_cnt <= ne_cnt + 8'h01;
		end
	end

	// Two matching samples on successive ticks are needed to move the level
	always_ff @(posedge mclk) begin
		if (srst) begin
			ne_smp <= 1'b0;
			ne_lvl <= 1'b0;
		end else if (ne_tick) begin
			ne_smp <= pin_s3[1];
			if (pin_s3[1] == ne_smp) begin
				ne_lvl <= ne_smp;
			end
		end
	end

	// ----------------------------------------
	// Edge events
	// ----------------------------------------
	logic       a_lvl;
	logic       a_d;
	logic       a_rise;
	logic       a_fall;
	logic       ev_both;
	logic       ev_a;
	logic       ev_b;
	logic       ev_test;
	logic       ev_key;
	logic [3:0] key_mask;
	logic [4:0] evt;

	assign a_lvl = mode_a.noise_en ? ne_lvl : lvl[1];

	// Keeps tracking through a system reset, so its release shows no false edge
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			a_d <= 1'b0;
		end else begin
			a_d <= a_lvl;
		end
	end

	assign a_rise = a_lvl && !a_d;
	assign a_fall = !a_lvl && a_d;

	assign ev_both = rise[0] || fall[0];

	always_comb begin
		unique case (mode_a.edge_sel)
			EEI_RISE: ev_a = a_rise;
			EEI_FALL: ev_a = a_fall;
			EEI_BOTH: ev_a = a_rise || a_fall;
			EEI_OFF:  ev_a = 1'b0;
		endcase
	end

	assign ev_b     = mode_b ? fall[2] : rise[2];
	assign ev_test  = rise[3] && !mode_c[EEI_TEST_OFF_BIT];
	assign key_mask = mode_c[EEI_KEY_ALL_BIT] ? EEI_KEY_ALL : EEI_KEY_UPPER;
	assign ev_key   = |(fall[7:4] & key_mask);
	assign evt      = {ev_key, ev_test, ev_b, ev_a, ev_both};

	// ----------------------------------------
	// Sticky flags and interrupt
	// ----------------------------------------
	logic [4:0] stat;
	logic [4:0] clr;
	logic [4:0] next_stat;

	assign clr = (wr && avs_address == EEI_OFF_CLR) ? avs_writedata[4:0] : 5'h00;

	// Set wins over a clear or acknowledge in the same cycle
	assign next_stat = (stat & ~(clr | {2'h0, vec_ack})) | evt;

	always_ff @(posedge mclk) begin
		if (srst) begin
			stat <= 5'h00;
		end else begin
			stat <= next_stat;
		end
	end

	assign test_input_flag = stat[3];

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat & en);
		end
	end

	// ----------------------------------------
	// Standby release and CPU reset
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			standby_release <= 1'b0;
		end else begin
			standby_release <= ev_both || ev_b || ev_test
			                || (ev_a && !mode_a.noise_en)
			                || fall[8];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cpu_reset_req <= 1'b1;
		end else begin
			cpu_reset_req <= !lvl[8];
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address)
			EEI_OFF_MODE_A: rd_mux[3:0] = mode_a;
			EEI_OFF_MODE_B: rd_mux[0]   = mode_b;
			EEI_OFF_MODE_C: rd_mux[1:0] = mode_c;
			EEI_OFF_STAT:   rd_mux[4:0] = stat;
			EEI_OFF_EN:     rd_mux[4:0] = en;
			EEI_OFF_PINS:   rd_mux[8:0] = lvl;
			default:        rd_mux      = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_mux;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_both_change;
		(lvl[0] != lvl_d[0]) && lvl[8];
	endsequence

	sequence s_sys_fall;
		lvl[8] ##1 !lvl[8];
	endsequence

	property p_both_flag;
		s_both_change |=> stat[0];
	endproperty
	a_both_flag: assert property (p_both_flag) else $error("both-edge flag not set");

	property p_both_wake;
		s_both_change |=> standby_release;
	endproperty
	a_both_wake: assert property (p_both_wake) else $error("both-edge no wake");

	property p_a_off;
		mode_a.edge_sel == EEI_OFF && lvl[8] && !vec_ack[1] && !clr[1] && !stat[1]
			|=> !stat[1];
	endproperty
	a_a_off: assert property (p_a_off) else $error("disabled input a raised flag");

	property p_b_fall;
		!mode_b && lvl[8] && lvl_d[2] && !lvl[2] && !stat[2] && !vec_ack[2]
			|=> !stat[2];
	endproperty
	a_b_fall: assert property (p_b_fall) else $error("input b fired on wrong edge");

	property p_mode_rst;
		$rose(rst_b) |-> mode_a == EEI_MODE_A_RST && mode_b == EEI_MODE_B_RST
			&& mode_c == EEI_MODE_C_RST;
	endproperty
	a_mode_rst: assert property (p_mode_rst) else $error("modes not cleared");

	property p_ne_nowake;
		ev_a && mode_a.noise_en && !ev_both && !ev_b && !ev_test && !fall[8]
			|=> !standby_release;
	endproperty
	a_ne_nowake: assert property (p_ne_nowake) else $error("filtered input woke");

	property p_test_flag;
		rise[3] && !mode_c[EEI_TEST_OFF_BIT] && lvl[8] |=> test_input_flag && standby_release;
	endproperty
	a_test_flag: assert property (p_test_flag) else $error("test flag missed");

	property p_key_low;
		!mode_c[EEI_KEY_ALL_BIT] && lvl[8] && |fall[5:4] && !(|fall[7:6])
			&& !stat[4] |=> !stat[4];
	endproperty
	a_key_low: assert property (p_key_low) else $error("masked key raised request");

	property p_sys_reset;
		s_sys_fall |=> standby_release && cpu_reset_req && stat == 5'h00;
	endproperty
	a_sys_reset: assert property (p_sys_reset) else $error("system reset not applied");

	property p_hold;
		stat[0] && lvl[8] && !clr[0] && !vec_ack[0] |=> stat[0] [*1];
	endproperty
	a_hold: assert property (p_hold) else $error("flag lost");

endmodule

// ==== bench/eei_src_model.sv ====
// Model of the interrupt, test and key signal sources that drive the pins
`timescale 1ns/1ns

module eei_src_model (
	input  wire logic          mclk, // Bench clock, levels change just after its edge
	output eei_pkg::eei_pins_s pins  // Pin levels seen by the block
);
	import eei_pkg::*;

	// ----------------------------------------
	// Pin levels
	// ----------------------------------------
	// Keys idle high on their pull-ups, system reset idles released
	initial pins = eei_pins_s'(EEI_PIN_RST);

	// Hold a new level for n edges; slow or short holds come from the caller
	task automatic hold(input int idx, input logic val, input int n);
		logic [8:0] v;
		v = pins;
		v[idx] = val;
		pins <= eei_pins_s'(v);
		repeat (n) @(posedge mclk);
	endtask
endmodule

// ==== bench/eei_top_tb.sv ====
// Self-checking bench of the external edge interrupt block
`timescale 1ns/1ns
`define CHK(g, w) begin n_tests++; if ((g) !== (w)) begin errors++; \
	$display("unexpected t=%0t got %h want %h", $time, g, w); end end

module eei_top_tb;
	import eei_pkg::*;
	logic        mclk, rst_b, avs_read, avs_write, avs_waitrequest;
	logic        irq, test_input_flag, cpu_reset_req, standby_release;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [2:0]  vec_ack;
	eei_pins_s   pins;
	int          errors, n_tests, wakes, w0, exp_st, seed;

	eei_src_model u_src (.mclk, .pins);
	eei_top u_dut (.mclk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .pins, .vec_ack, .irq, .test_input_flag,
		.cpu_reset_req, .standby_release);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	always @(posedge mclk) if (standby_release === 1'b1) wakes++;

	task automatic test_done();
		if (errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Bus master and behavioural model
	// ----------------------------------------
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			errors++;
			test_done();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask

	task automatic rd(input logic [4:0] a, input int e);
		acc(1'b0, a, 32'h0);
		`CHK(q, 32'(e))
	endtask

	// Level change held long enough, with a random extra hold
	task automatic step(input int idx, input logic val);
		u_src.hold(idx, val, 20 + {$random(seed)} % 8);
	endtask

	task automatic clr();
		wr(EEI_OFF_CLR, 32'h1f);
		exp_st = 0;
	endtask

	function automatic bit hit(input int m, input logic r);
		return m == EEI_BOTH || (m == EEI_RISE && r) || (m == EEI_FALL && !r);
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{errors, n_tests, wakes, exp_st} = '0;
		seed = 32'h62797f6f;
		{rst_b, avs_read, avs_write, avs_address, avs_writedata, vec_ack} = '0;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (2) @(posedge mclk);
		`CHK(cpu_reset_req, 1'b0)
		rd(EEI_OFF_MODE_A, 0);
		rd(EEI_OFF_MODE_B, 0);
		rd(EEI_OFF_MODE_C, 0);
		rd(5'h1c, 0);
		rd(EEI_OFF_PINS, EEI_PIN_RST);
		w0 = $random(seed);
		wr(EEI_OFF_EN, 32'(w0));
		rd(EEI_OFF_EN, w0 & 32'h1f);
		wr(EEI_OFF_EN, 32'h0);
		w0 = wakes;
		step(0, 1'b1);
		rd(EEI_OFF_STAT, 1);
		`CHK(wakes, w0 + 1)
		clr();
		step(0, 1'b0);
		rd(EEI_OFF_STAT, 1);
		vec_ack <= 3'h1;
		@(posedge mclk);
		vec_ack <= 3'h0;
		repeat (3) @(posedge mclk);
		rd(EEI_OFF_STAT, 0);
		// A glitch shorter than the minimum width must vanish
		u_src.hold(0, 1'b1, 3);
		step(0, 1'b0);
		rd(EEI_OFF_STAT, 0);
		for (int m = 0; m < 4; m++) begin
			wr(EEI_OFF_MODE_A, 32'(m));
			for (int r = 1; r >= 0; r--) begin
				clr();
				step(1, r[0]);
				if (hit(m, r[0])) exp_st = 2;
				rd(EEI_OFF_STAT, exp_st);
			end
		end
		for (int m = 0; m < 2; m++) begin
			wr(EEI_OFF_MODE_B, 32'(m));
			for (int r = 1; r >= 0; r--) begin
				clr();
				step(2, r[0]);
				if (hit(m, r[0])) exp_st = 4;
				rd(EEI_OFF_STAT, exp_st);
			end
		end
		clr();
		w0 = wakes;
		step(3, 1'b1);
		`CHK(test_input_flag, 1'b1)
		`CHK(wakes, w0 + 1)
		clr();
		wr(EEI_OFF_MODE_C, 32'h2);
		step(3, 1'b0);
		step(3, 1'b1);
		`CHK(test_input_flag, 1'b0)
		wr(EEI_OFF_MODE_C, 32'h0);
		step(4, 1'b0);
		rd(EEI_OFF_STAT, 0);
		step(7, 1'b0);
		rd(EEI_OFF_STAT, 16);
		clr();
		step(7, 1'b1);
		rd(EEI_OFF_STAT, 0);
		wr(EEI_OFF_MODE_C, 32'h1);
		step(4, 1'b1);
		step(4, 1'b0);
		rd(EEI_OFF_STAT, 16);
		// Filtered input a needs two agreeing ticks, so hold well past them
		wr(EEI_OFF_MODE_A, 32'h4);
		clr();
		w0 = wakes;
		u_src.hold(1, 1'b1, 300);
		rd(EEI_OFF_STAT, 2);
		`CHK(wakes, w0)
		wr(EEI_OFF_EN, 32'h2);
		repeat (3) @(posedge mclk);
		`CHK(irq, 1'b1)
		wr(EEI_OFF_EN, 32'h0);
		repeat (3) @(posedge mclk);
		`CHK(irq, 1'b0)
		wr(EEI_OFF_EN, 32'h2);
		wr(EEI_OFF_CLR, 32'h2);
		repeat (3) @(posedge mclk);
		`CHK(irq, 1'b0)
		// Slow sampling must still reject what the fast clock would pass
		wr(EEI_OFF_MODE_A, 32'hd);
		clr();
		w0 = wakes;
		u_src.hold(1, 1'b0, 200);
		rd(EEI_OFF_STAT, 0);
		u_src.hold(1, 1'b0, 600);
		rd(EEI_OFF_STAT, 2);
		`CHK(wakes, w0)
		w0 = wakes;
		step(8, 1'b0);
		`CHK(cpu_reset_req, 1'b1)
		`CHK(wakes, w0 + 1)
		step(8, 1'b1);
		`CHK(cpu_reset_req, 1'b0)
		rd(EEI_OFF_MODE_A, 0);
		rd(EEI_OFF_MODE_C, 0);
		rd(EEI_OFF_EN, 0);
		test_done();
	end

	// Whole run is a few thousand cycles; this span leaves a wide margin
	initial begin
		repeat (40000) @(posedge mclk);
		errors++;
		test_done();
	end
endmodule
